//--- dv/dspa_accum_monitor.sv
`timescale 1ns/1ps
`default_nettype none
`include "dspa_defs.vh"
// ==========================================================
// Port checker for the accumulator back end
module dspa_accum_mon (
  // Clock, reset and APB
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] prdata,
  // Sequencer requests
  input wire        acc_op_valid,
  input wire        shift_valid,
  input wire        shift_from_bus,
  input wire [5:0]  shift_amount,
  input wire [15:0] shift_bus_data,
  input wire [15:0] shift_bus_result,
  input wire        store_valid,
  input wire [15:0] store_addr,
  input wire        wb_valid,
  input wire [2:0]  wb_opcode,
  input wire        wb_indirect,
  // Results
  input wire        xbus_wr_en,
  input wire [15:0] xbus_addr,
  input wire        overflow_trap_req,
  input wire        catastrophic_trap_req
);
  default clocking mon_cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Qualifiers; a store beats a write-back in the same cycle
  wire wr_any  = psel && penable && pwrite;
  wire wb_mem  = wb_valid && wb_indirect && !wb_opcode[2] && !store_valid;
  wire rd_stat = psel && !penable && !pwrite && (paddr == `DSPA_OFS_STATUS);
  // ==========================================================
  // Assertions
  a_store_to_bus: assert property (
    store_valid |=> xbus_wr_en && xbus_addr == $past(store_addr))
    else $error("store missing on bus");
  a_write_cause: assert property (
    xbus_wr_en |-> $past(store_valid) || $past(wb_mem))
    else $error("bus write without request");
  a_wb_skip_op: assert property (
    wb_valid && wb_opcode[2] && !store_valid |=> !xbus_wr_en)
    else $error("ineligible write-back wrote");
  a_ptr_step: assert property (
    wb_mem ##1 wb_mem |=> xbus_addr == $past(xbus_addr) + `DSPA_PTR_STEP)
    else $error("pointer step wrong");
  a_shift_zero: assert property (
    shift_valid && shift_from_bus && shift_amount == 6'h00
      |=> shift_bus_result == $past(shift_bus_data))
    else $error("zero shift changed data");
  a_status_or: assert property (
    rd_stat |=> prdata[4] == (prdata[0] | prdata[1]) && prdata[5] == (prdata[2] | prdata[3]))
    else $error("combined status bits wrong");
  a_trap_hold: assert property (
    !acc_op_valid && !wr_any |=> $stable(overflow_trap_req) && $stable(catastrophic_trap_req))
    else $error("trap level moved on its own");
  a_sat_sticky: assert property (
    $fell(catastrophic_trap_req) |-> $past(wr_any))
    else $error("saturation trap cleared by hardware");
  // Main scenarios
  c_store: cover property (store_valid ##1 xbus_wr_en);
  c_wb_pair: cover property (wb_mem ##1 wb_mem);
  c_cat_trap: cover property ($rose(catastrophic_trap_req));
endmodule // dspa_accum_mon
`default_nettype wire

//--- dv/dspa_xmem.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Data-space write sink on the X bus
module dspa_xmem (
  // Clock and reset
  input  wire         pclk,
  input  wire         presetn,
  // X bus write side
  input  wire         xbus_wr_en,
  input  wire  [15:0] xbus_addr,
  input  wire  [15:0] xbus_wdata,
  // Last word taken
  output logic [15:0] last_addr,
  output logic [15:0] last_data,
  output logic [7:0]  wr_count
);
  // One strobe is one whole word; a held strobe would count twice
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {last_addr, last_data, wr_count} <= '0;
    end else if (xbus_wr_en) begin
      {last_addr, last_data} <= {xbus_addr, xbus_wdata};
      wr_count <= wr_count + 8'h01;
    end
  end
endmodule // dspa_xmem
`default_nettype wire

//--- dv/tb_dspa_accum.sv
`timescale 1ns/1ps
`default_nettype none
`include "dspa_defs.vh"
// ==========================================================
// Bench for the accumulator back end
module tb_dspa_accum;
  logic        pclk, presetn, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, q;
  logic        acc_op_valid, acc_op_target, acc_op_sub, acc_op_load, acc_op_shifted;
  logic [39:0] acc_op_operand, v;
  logic        shift_valid, shift_from_bus, shift_src, shift_arith;
  logic [5:0]  shift_amount;
  logic [15:0] shift_bus_data, store_addr;
  logic        store_valid, store_src, store_rounded, wb_valid, wb_target, wb_indirect;
  logic [2:0]  wb_opcode;
  logic [7:0]  nw;
  wire         pready, pslverr, xbus_wr_en;
  wire         overflow_trap_req, catastrophic_trap_req, arith_trap_req;
  wire  [31:0] prdata;
  wire  [15:0] shift_bus_result, xbus_addr, xbus_wdata, m_addr, m_data;
  wire  [7:0]  m_count;
  int          num_errors, checks, i;
  // Store cases: source, config (bit 0 asks a rounded store), word
  logic [39:0] ra [11] = '{40'h0000128000, 40'h0000128000, 40'h0000128000, 40'h0000138000,
    40'h000012ffff, 40'h00001207ff, 40'h0112340000, 40'hfe12340000, 40'h0112340000,
    40'h007fff8000, 40'h007fff8000};
  logic [7:0]  rc [11] = '{8'h00, 8'h01, 8'h03, 8'h03, 8'h03, 8'h01, 8'h20, 8'h20, 8'h00,
    8'h21, 8'h01};
  logic [15:0] re [11] = '{16'h0012, 16'h0013, 16'h0012, 16'h0014, 16'h0013, 16'h0012,
    16'h7fff, 16'h8000, 16'h1234, 16'h7fff, 16'h8000};
  // Bus shift cases: data, signed amount, result (case 1 is logical)
  logic [15:0] sd [6] = '{16'h8000, 16'h8000, 16'h8001, 16'h1234, 16'h8000, 16'h0001};
  logic [5:0]  sa [6] = '{6'h04, 6'h04, 6'h3c, 6'h00, 6'h10, 6'h30};
  logic [15:0] se [6] = '{16'hf800, 16'h0800, 16'h0010, 16'h1234, 16'hffff, 16'h0000};

  dspa_accum uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .acc_op_valid(acc_op_valid), .acc_op_target(acc_op_target),
    .acc_op_sub(acc_op_sub), .acc_op_load(acc_op_load), .acc_op_shifted(acc_op_shifted),
    .acc_op_operand(acc_op_operand), .shift_valid(shift_valid),
    .shift_from_bus(shift_from_bus), .shift_src(shift_src), .shift_arith(shift_arith),
    .shift_amount(shift_amount), .shift_bus_data(shift_bus_data),
    .shift_bus_result(shift_bus_result), .store_valid(store_valid), .store_src(store_src),
    .store_rounded(store_rounded), .store_addr(store_addr), .wb_valid(wb_valid),
    .wb_opcode(wb_opcode), .wb_target(wb_target), .wb_indirect(wb_indirect),
    .xbus_wr_en(xbus_wr_en), .xbus_addr(xbus_addr), .xbus_wdata(xbus_wdata),
    .overflow_trap_req(overflow_trap_req), .catastrophic_trap_req(catastrophic_trap_req),
    .arith_trap_req(arith_trap_req));
  dspa_xmem u_mem (.pclk(pclk), .presetn(presetn), .xbus_wr_en(xbus_wr_en),
    .xbus_addr(xbus_addr), .xbus_wdata(xbus_wdata), .last_addr(m_addr),
    .last_data(m_data), .wr_count(m_count));

  // ==========================================================
  // Clock, 50 ns period
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  // Verdict; the only exit of the run
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // APB transfer; request held until pready is seen, read word lands in q
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      num_errors++;
      complete_run;
    end
    q = prdata;
    {psel, penable} <= 2'b00;
  endtask
  task automatic racc(input logic b, output logic [39:0] r);
    apb(1'b0, b ? `DSPA_OFS_ACCB_LO : `DSPA_OFS_ACCA_LO, 32'h0);
    r[31:0] = q;
    apb(1'b0, b ? `DSPA_OFS_ACCB_HI : `DSPA_OFS_ACCA_HI, 32'h0);
    r[39:32] = q[7:0];
  endtask
  task automatic op(input logic t, input logic s, input logic ld, input logic sh,
                    input logic [39:0] d);
    @(posedge pclk);
    {acc_op_valid, acc_op_target, acc_op_sub, acc_op_load, acc_op_shifted, acc_op_operand}
      <= {1'b1, t, s, ld, sh, d};
    @(posedge pclk);
    acc_op_valid <= 1'b0;
  endtask
  // Store (w=0) or write-back (w=1); nw counts the bus writes that follow
  task automatic xfer(input logic w, input logic s, input logic r, input logic [2:0] o);
    logic [7:0] c0;
    c0 = m_count;
    @(posedge pclk);
    {store_valid, store_src, store_rounded} <= {!w, s, r};
    {wb_valid, wb_target, wb_indirect, wb_opcode} <= {w, s, r, o};
    @(posedge pclk);
    {store_valid, wb_valid} <= 2'b00;
    repeat (3) @(posedge pclk);
    nw = m_count - c0;
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    {psel, penable, pwrite, paddr, pwdata, acc_op_valid, acc_op_target} = '0;
    {acc_op_sub, acc_op_load, acc_op_shifted, acc_op_operand, shift_valid} = '0;
    {shift_from_bus, shift_src, shift_arith, shift_amount, shift_bus_data} = '0;
    {store_valid, store_src, store_rounded, wb_valid, wb_target, wb_indirect, wb_opcode} = '0;
    {num_errors, checks} = '0;
    store_addr = 16'h0400;
    presetn = 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    // 40-bit saturation on A with guard trap enabled
    apb(1'b1, `DSPA_OFS_CONFIG, 32'h90);
    apb(1'b1, `DSPA_OFS_TRAP, 32'h2);
    op(0, 0, 1, 0, 40'h7f00000000);
    apb(1'b0, `DSPA_OFS_STATUS, 32'h0);
    chk(q[5:0], 6'h11);
    chk(overflow_trap_req, 1'b1);
    op(0, 0, 0, 0, 40'h7f00000000);
    racc(0, v);
    chk(v, 40'h7fffffffff);
    apb(1'b0, `DSPA_OFS_STATUS, 32'h0);
    chk(q[5:0], 6'h35);
    op(0, 0, 1, 0, 40'h8000000001);
    op(0, 1, 0, 0, 40'h0000000002);
    racc(0, v);
    chk(v, 40'h8000000000);
    op(0, 0, 1, 0, 40'h0);
    apb(1'b0, `DSPA_OFS_STATUS, 32'h0);
    chk(q[5:0], 6'h24);
    chk(overflow_trap_req, 1'b0);
    apb(1'b1, `DSPA_OFS_STATUS, 32'h4);
    apb(1'b0, `DSPA_OFS_STATUS, 32'h0);
    chk(q[5:0], 6'h00);
    // 32-bit saturation on A, a guard overflow hidden by the clamp
    apb(1'b1, `DSPA_OFS_CONFIG, 32'h80);
    op(0, 0, 1, 0, 40'h007fffffff);
    op(0, 0, 0, 0, 40'h0100000000);
    racc(0, v);
    chk(v, 40'h007fffffff);
    apb(1'b0, `DSPA_OFS_STATUS, 32'h0);
    chk(q[5:0], 6'h24);
    op(0, 0, 1, 0, 40'hff80000000);
    op(0, 1, 0, 0, 40'h0000000001);
    racc(0, v);
    chk(v, 40'hff80000000);
    // Saturation off: wrap, sticky flag, catastrophic trap
    apb(1'b1, `DSPA_OFS_CONFIG, 32'h00);
    apb(1'b1, `DSPA_OFS_STATUS, 32'h4);
    apb(1'b1, `DSPA_OFS_TRAP, 32'h1);
    op(0, 0, 1, 0, 40'h7fffffffff);
    op(0, 0, 0, 0, 40'h0000000001);
    racc(0, v);
    chk(v, 40'h8000000000);
    apb(1'b0, `DSPA_OFS_STATUS, 32'h0);
    chk(q[2], 1'b1);
    chk(catastrophic_trap_req, 1'b1);
    chk(arith_trap_req, 1'b1);
    apb(1'b1, `DSPA_OFS_CONFIG, 32'h80);
    apb(1'b0, `DSPA_OFS_STATUS, 32'h0);
    chk(catastrophic_trap_req, 1'b0);
    chk(arith_trap_req, 1'b0);
    apb(1'b1, `DSPA_OFS_TRAP, 32'h0);
    $display("adder tests done");
    // Stores from B: rounding modes and write saturation
    for (i = 0; i < 11; i++) begin
      apb(1'b1, `DSPA_OFS_CONFIG, {24'h0, rc[i]});
      op(1, 0, 1, 0, ra[i]);
      xfer(0, 1, rc[i][0], 3'h0);
      chk(m_data, re[i]);
      chk(m_addr, 16'h0400);
    end
    racc(1, v);
    chk(v, 40'h007fff8000);
    $display("store tests done");
    // Write-back of A through the pointer, every opcode
    apb(1'b1, `DSPA_OFS_CONFIG, 32'h0);
    apb(1'b1, `DSPA_OFS_WBPTR, 32'h0100);
    op(0, 0, 1, 0, 40'h0000128000);
    for (i = 0; i < 8; i++) begin
      xfer(1, 1, 1, i[2:0]);
      chk(nw, {7'h0, i < 4});
    end
    chk(m_data, 16'h0013);
    chk(m_addr, 16'h0106);
    apb(1'b0, `DSPA_OFS_WBPTR, 32'h0);
    chk(q[15:0], 16'h0108);
    // Back to back write-backs must step the pointer between them
    @(posedge pclk);
    {wb_valid, wb_opcode} <= {1'b1, 3'h1};
    repeat (2) @(posedge pclk);
    wb_valid <= 1'b0;
    repeat (3) @(posedge pclk);
    chk(m_addr, 16'h010a);
    apb(1'b1, `DSPA_OFS_CONFIG, 32'h02);
    xfer(1, 1, 0, 3'h0);
    chk(nw, 8'h00);
    apb(1'b0, `DSPA_OFS_WBPTR, 32'h0);
    chk(q[15:0], 16'h0012);
    $display("write-back tests done");
    // Bus shifts
    for (i = 0; i < 6; i++) begin
      @(posedge pclk);
      {shift_valid, shift_from_bus, shift_arith} <= {1'b1, 1'b1, i != 1};
      {shift_amount, shift_bus_data} <= {sa[i], sd[i]};
      @(posedge pclk);
      shift_valid <= 1'b0;
      @(posedge pclk);
      chk(shift_bus_result, se[i]);
    end
    // Accumulator shifts of A loaded into B
    op(0, 0, 1, 0, 40'h0012345678);
    {shift_from_bus, shift_src, shift_amount} <= {1'b0, 1'b0, 6'h04};
    op(1, 0, 1, 1, 40'h0);
    racc(1, v);
    chk(v, 40'h0001234567);
    shift_amount <= 6'h38;
    op(1, 0, 1, 1, 40'h0);
    racc(1, v);
    chk(v, 40'h1234567800);
    $display("shift tests done");
    complete_run;
  end
  // Hang guard
  initial begin
    repeat (100000) @(posedge pclk);
    num_errors++;
    complete_run;
  end
endmodule // tb_dspa_accum

bind dspa_accum dspa_accum_mon u_mon (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
  .acc_op_valid(acc_op_valid), .shift_valid(shift_valid), .shift_from_bus(shift_from_bus),
  .shift_amount(shift_amount), .shift_bus_data(shift_bus_data),
  .shift_bus_result(shift_bus_result), .store_valid(store_valid), .store_addr(store_addr),
  .wb_valid(wb_valid), .wb_opcode(wb_opcode), .wb_indirect(wb_indirect),
  .xbus_wr_en(xbus_wr_en), .xbus_addr(xbus_addr), .overflow_trap_req(overflow_trap_req),
  .catastrophic_trap_req(catastrophic_trap_req));
`default_nettype wire

//--- hdl/dspa_accum.v
`timescale 1ns/1ps
`default_nettype none
`include "dspa_defs.vh"
module dspa_accum (
  // Clock and reset
  input  wire        pclk,
  input  wire        presetn,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output reg  [31:0] prdata,
  output wire        pslverr,
  // Adder/subtracter operation from sequencer
  input  wire        acc_op_valid,
  input  wire        acc_op_target,
  input  wire        acc_op_sub,
  input  wire        acc_op_load,
  input  wire        acc_op_shifted,
  input  wire [39:0] acc_op_operand,
  // Shifter controls
  input  wire        shift_valid,
  input  wire        shift_from_bus,
  input  wire        shift_src,
  input  wire        shift_arith,
  input  wire [5:0]  shift_amount,
  input  wire [15:0] shift_bus_data,
  output reg  [15:0] shift_bus_result,
  // Accumulator store
  input  wire        store_valid,
  input  wire        store_src,
  input  wire        store_rounded,
  input  wire [15:0] store_addr,
  // Multiply-accumulate write-back
  input  wire        wb_valid,
  input  wire [2:0]  wb_opcode,
  input  wire        wb_target,
  input  wire        wb_indirect,
  // X bus write
  output reg         xbus_wr_en,
  output reg  [15:0] xbus_addr,
  output reg  [15:0] xbus_wdata,
  // Trap requests
  output wire        overflow_trap_req,
  output wire        catastrophic_trap_req,
  output wire        arith_trap_req
);
  // ==========================================================
  // State
  reg  [39:0] acc_a;
  reg  [39:0] acc_b;
  reg  [7:0]  core_config_reg;
  reg  [2:0]  trap_control_reg;
  reg  [1:0]  guard_ovf;
  reg  [1:0]  saturated;
  reg  [15:0] writeback_pointer_reg;

  wire acc_a_sat_en     = core_config_reg[`DSPA_CFG_SAT_A];
  wire acc_b_sat_en     = core_config_reg[`DSPA_CFG_SAT_B];
  wire acc_sat_mode_sel = core_config_reg[`DSPA_CFG_MODE];
  wire rounding_mode_sel = core_config_reg[`DSPA_CFG_ROUND];
  wire data_write_sat_en = core_config_reg[`DSPA_CFG_WSAT];
  wire catastrophic_trap_en   = trap_control_reg[`DSPA_TRP_COV];
  wire acc_a_overflow_trap_en = trap_control_reg[`DSPA_TRP_OVA];
  wire acc_b_overflow_trap_en = trap_control_reg[`DSPA_TRP_OVB];
  wire acc_a_guard_overflow = guard_ovf[0];
  wire acc_b_guard_overflow = guard_ovf[1];
  wire acc_a_saturated      = saturated[0];
  wire acc_b_saturated      = saturated[1];
  wire any_guard_overflow = acc_a_guard_overflow | acc_b_guard_overflow;
  wire any_saturated      = acc_a_saturated | acc_b_saturated;

  // ==========================================================
  // APB decode; zero wait states
  wire        apb_wr = psel & penable & pwrite;
  wire        apb_rd_hit;
  reg         addr_ok;
  wire [1:0]  sat_clr;

  always @* begin
    case (paddr)
      `DSPA_OFS_CONFIG, `DSPA_OFS_TRAP, `DSPA_OFS_STATUS, `DSPA_OFS_WBPTR,
      `DSPA_OFS_ACCA_LO, `DSPA_OFS_ACCA_HI, `DSPA_OFS_ACCB_LO,
      `DSPA_OFS_ACCB_HI: addr_ok = 1'b1;
      default:           addr_ok = 1'b0;
    endcase
  end

  assign pready     = 1'b1;
  assign pslverr    = psel & penable & ~addr_ok;
  assign apb_rd_hit = psel & ~penable & ~pwrite;
  // Write one to clear; only software can drop these
  assign sat_clr = (apb_wr && paddr == `DSPA_OFS_STATUS) ?
                   {pwdata[`DSPA_ST_SAT_B], pwdata[`DSPA_ST_SAT_A]} : 2'b00;

  // ==========================================================
  // Shifter feeds the adder and the bus result
  wire [39:0] shift_result;
  wire [15:0] shift_bus_word;

  dspa_shift u_shift (
    .acc_in     (shift_src ? acc_b : acc_a),
    .bus_in     (shift_bus_data),
    .from_bus   (shift_from_bus),
    .arith      (shift_arith),
    .amount     (shift_amount),
    .result     (shift_result),
    .bus_result (shift_bus_word)
  );

  // ==========================================================
  // Adder with overflow and saturation, once per accumulator
  wire [39:0] opnd = acc_op_shifted ? shift_result : acc_op_operand;
  wire [79:0] next_acc_flat;
  wire [1:0]  next_guard;
  wire [1:0]  sat_set;
  wire [1:0]  sat_en_vec = {acc_b_sat_en, acc_a_sat_en};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_acc
      wire [39:0] cur  = (gi == 0) ? acc_a : acc_b;
      wire        hit  = acc_op_valid & (acc_op_target == gi);
      wire [40:0] ea   = {cur[39], cur};
      wire [40:0] eo   = {opnd[39], opnd};
      wire [40:0] sum  = acc_op_load ? eo : (acc_op_sub ? (ea - eo) : (ea + eo));
      wire [39:0] raw  = sum[39:0];
      wire        neg  = sum[40];
      wire        ovf39 = sum[40] ^ sum[39];
      wire        gdiff = ~(&raw[39:32] | ~|raw[39:32]);
      wire        ovf31 = ovf39 | ~(&raw[39:31] | ~|raw[39:31]);
      wire        sat_on = sat_en_vec[gi];
      wire        m40  = sat_on & acc_sat_mode_sel;
      wire        m32  = sat_on & ~acc_sat_mode_sel;
      wire        trip = m32 ? ovf31 : ovf39;
      reg  [39:0] res;
      // Clamp by mode; with saturation off the sum wraps
      always @* begin
        res = raw;
        if (m40 && ovf39)
          res = neg ? `DSPA_MIN40 : `DSPA_MAX40;
        else if (m32 && ovf31)
          res = neg ? `DSPA_MIN32 : `DSPA_MAX32;
      end
      assign next_acc_flat[gi*40 +: 40] = hit ? res : cur;
      assign next_guard[gi] = hit ? (gdiff & ~m32) : guard_ovf[gi];
      assign sat_set[gi]    = hit & trip;
    end
  endgenerate

  // ==========================================================
  // Rounding and write saturation for store and write-back
  wire wb_ok = wb_valid & ~store_valid &
               (wb_opcode != `DSPA_MAC_MULT) & (wb_opcode != `DSPA_MAC_NMUL) &
               (wb_opcode != `DSPA_MAC_DIST) & (wb_opcode != `DSPA_MAC_DACC);
  // Write-back reads the non-target accumulator
  wire        rs_src   = store_valid ? store_src : ~wb_target;
  wire        rs_round = store_valid ? store_rounded : 1'b1;
  wire [15:0] rs_data;

  dspa_round_sat u_round (
    .acc        (rs_src ? acc_b : acc_a),
    .round_en   (rs_round),
    .convergent (rounding_mode_sel),
    .wr_sat     (data_write_sat_en),
    .data       (rs_data)
  );

  // ==========================================================
  // Accumulators and flags; set beats a same-cycle clear
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_a     <= `DSPA_ACC_RESET;
      acc_b     <= `DSPA_ACC_RESET;
      guard_ovf <= 2'b00;
      saturated <= 2'b00;
    end else begin
      acc_a     <= next_acc_flat[39:0];
      acc_b     <= next_acc_flat[79:40];
      guard_ovf <= next_guard;
      saturated <= (saturated & ~sat_clr) | sat_set;
    end
  end

  // ==========================================================
  // Configuration registers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_config_reg  <= `DSPA_CFG_RESET;
      trap_control_reg <= `DSPA_TRP_RESET;
    end else if (apb_wr) begin
      if (paddr == `DSPA_OFS_CONFIG)
        core_config_reg <= pwdata[7:0];
      if (paddr == `DSPA_OFS_TRAP)
        trap_control_reg <= pwdata[2:0];
    end
  end

  // ==========================================================
  // Store, write-back and X bus; hardware update wins over APB
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      writeback_pointer_reg <= 16'h0000;
      xbus_wr_en            <= 1'b0;
      xbus_addr             <= 16'h0000;
      xbus_wdata            <= 16'h0000;
    end else begin
      xbus_wr_en <= 1'b0;
      if (apb_wr && paddr == `DSPA_OFS_WBPTR)
        writeback_pointer_reg <= pwdata[15:0];
      if (store_valid) begin
        xbus_wr_en <= 1'b1;
        xbus_addr  <= store_addr;
        xbus_wdata <= rs_data;
      end else if (wb_ok && wb_indirect) begin
        xbus_wr_en <= 1'b1;
        xbus_addr  <= writeback_pointer_reg;
        xbus_wdata <= rs_data;
        writeback_pointer_reg <= writeback_pointer_reg + `DSPA_PTR_STEP;
      end else if (wb_ok) begin
        writeback_pointer_reg <= rs_data;
      end
    end
  end

  // ==========================================================
  // Bus shift result, held until the next shift
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      shift_bus_result <= 16'h0000;
    else if (shift_valid)
      shift_bus_result <= shift_bus_word;
  end

  // ==========================================================
  // Read data captured in setup so it is stable in access
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (apb_rd_hit) begin
      case (paddr)
        `DSPA_OFS_CONFIG:  prdata <= {24'h000000, core_config_reg};
        `DSPA_OFS_TRAP:    prdata <= {29'h00000000, trap_control_reg};
        `DSPA_OFS_STATUS:  prdata <= {26'h0000000, any_saturated, any_guard_overflow,
                                      acc_b_saturated, acc_a_saturated,
                                      acc_b_guard_overflow, acc_a_guard_overflow};
        `DSPA_OFS_WBPTR:   prdata <= {16'h0000, writeback_pointer_reg};
        `DSPA_OFS_ACCA_LO: prdata <= acc_a[31:0];
        `DSPA_OFS_ACCA_HI: prdata <= {24'h000000, acc_a[39:32]};
        `DSPA_OFS_ACCB_LO: prdata <= acc_b[31:0];
        `DSPA_OFS_ACCB_HI: prdata <= {24'h000000, acc_b[39:32]};
        default:           prdata <= 32'h00000000;
      endcase
    end
  end

  // ==========================================================
  // Trap requests are levels; they drop with flag or enable
  assign overflow_trap_req = (acc_a_guard_overflow & acc_a_overflow_trap_en) |
                             (acc_b_guard_overflow & acc_b_overflow_trap_en);
  assign catastrophic_trap_req = catastrophic_trap_en &
                                 ((acc_a_saturated & ~acc_a_sat_en) |
                                  (acc_b_saturated & ~acc_b_sat_en));
  assign arith_trap_req = overflow_trap_req | catastrophic_trap_req;
endmodule // dspa_accum
`default_nettype wire

//--- hdl/dspa_defs.vh
`ifndef DSPA_DEFS_VH
`define DSPA_DEFS_VH
// ==========================================================
// APB register offsets
`define DSPA_OFS_CONFIG   12'h000
`define DSPA_OFS_TRAP     12'h004
`define DSPA_OFS_STATUS   12'h008
`define DSPA_OFS_WBPTR    12'h00c
`define DSPA_OFS_ACCA_LO  12'h010
`define DSPA_OFS_ACCA_HI  12'h014
`define DSPA_OFS_ACCB_LO  12'h018
`define DSPA_OFS_ACCB_HI  12'h01c
// ==========================================================
// Core configuration field positions
`define DSPA_CFG_ROUND    1
`define DSPA_CFG_MODE     4
`define DSPA_CFG_WSAT     5
`define DSPA_CFG_SAT_B    6
`define DSPA_CFG_SAT_A    7
`define DSPA_CFG_RESET    8'h00
// ==========================================================
// Trap control field positions
`define DSPA_TRP_COV      0
`define DSPA_TRP_OVA      1
`define DSPA_TRP_OVB      2
`define DSPA_TRP_RESET    3'h0
// ==========================================================
// Status field positions
`define DSPA_ST_GUARD_A   0
`define DSPA_ST_GUARD_B   1
`define DSPA_ST_SAT_A     2
`define DSPA_ST_SAT_B     3
`define DSPA_ST_ANY_GUARD 4
`define DSPA_ST_ANY_SAT   5
// ==========================================================
// Saturation limits
`define DSPA_MAX40        40'h7fffffffff
`define DSPA_MIN40        40'h8000000000
`define DSPA_MAX32        40'h007fffffff
`define DSPA_MIN32        40'hff80000000
`define DSPA_WMAX         16'h7fff
`define DSPA_WMIN         16'h8000
`define DSPA_WHI_LIM      24'h007fff
`define DSPA_WLO_LIM      24'hff8000
`define DSPA_LOW_HALF     16'h8000
// ==========================================================
// Multiply-accumulate opcodes seen at write-back
`define DSPA_MAC_MAC      3'h0
`define DSPA_MAC_MSC      3'h1
`define DSPA_MAC_MOVSAC   3'h2
`define DSPA_MAC_CLR      3'h3
`define DSPA_MAC_MULT     3'h4
`define DSPA_MAC_NMUL     3'h5
`define DSPA_MAC_DIST     3'h6
`define DSPA_MAC_DACC     3'h7
// ==========================================================
// Misc
`define DSPA_PTR_STEP     16'h0002
`define DSPA_ACC_RESET    40'h0000000000
`endif

//--- hdl/dspa_round_sat.v
`timescale 1ns/1ps
`default_nettype none
`include "dspa_defs.vh"
// ==========================================================
// Round and data write saturation
module dspa_round_sat (
  // Source accumulator and controls
  input  wire [39:0] acc,
  input  wire        round_en,
  input  wire        convergent,
  input  wire        wr_sat,
  // Store word
  output reg  [15:0] data
);
  reg        inc;
  reg [23:0] hi;

  // Round decision, then write saturation on the 24-bit high part
  always @* begin
    inc = 1'b0;
    if (round_en) begin
      if (acc[15:0] == `DSPA_LOW_HALF)
        inc = convergent ? acc[16] : 1'b1;
      else
        inc = acc[15];
    end
    hi   = acc[39:16] + {23'h000000, inc};
    data = hi[15:0];
    // Bit 39 gives the sign; a carry from -1 up to zero is no underflow
    if (wr_sat) begin
      if (!acc[39] && (hi > `DSPA_WHI_LIM))
        data = `DSPA_WMAX;
      else if (acc[39] && hi[23] && (hi < `DSPA_WLO_LIM))
        data = `DSPA_WMIN;
    end
  end
endmodule // dspa_round_sat
`default_nettype wire

//--- hdl/dspa_shift.v
`timescale 1ns/1ps
`default_nettype none
`include "dspa_defs.vh"
// ==========================================================
// 40-bit barrel shifter, signed amount
module dspa_shift (
  // Operand selection
  input  wire [39:0] acc_in,
  input  wire [15:0] bus_in,
  input  wire        from_bus,
  input  wire        arith,
  input  wire [5:0]  amount,
  // Results
  output reg  [39:0] result,
  output wire [15:0] bus_result
);
  reg  [39:0] opnd;
  reg  [4:0]  mag;
  wire        left = amount[5];

  // Place bus data by direction, then shift in one cycle
  always @* begin
    mag = left ? (5'h00 - amount[4:0]) : amount[4:0];
    if (from_bus)
      opnd = left ? {24'h000000, bus_in}
                  : {{8{arith & bus_in[15]}}, bus_in, 16'h0000};
    else
      opnd = acc_in;
    if (amount == 6'h00)
      result = opnd;
    else if (left)
      result = opnd << mag;
    else if (arith)
      result = $signed(opnd) >>> mag;
    else
      result = opnd >> mag;
  end

  // Bus result comes from the half the data was placed in
  assign bus_result = left ? result[15:0] : result[31:16];
endmodule // dspa_shift
`default_nettype wire
